/* pattern_output_map.svh */
// Purpose: Offsets, field positions and reset values of the pattern output unit.
// Assumes: 8-bit register port, registers indexed by a 4-bit address.
// Notes: Definitions only; included by its bare name.
`ifndef PATTERN_OUTPUT_MAP_SVH
`define PATTERN_OUTPUT_MAP_SVH

// Register indices on the register port
`define OFS_NEXT_LOW 4'h0
`define OFS_NEXT_HIGH 4'h1
`define OFS_ENABLE_LOW 4'h2
`define OFS_ENABLE_HIGH 4'h3
`define OFS_TRIGGER_SEL 4'h4
`define OFS_GROUP_MODE 4'h5
`define OFS_PORT_LOW 4'h6
`define OFS_PORT_HIGH 4'h7
`define OFS_FUNC_HIGH_UP 4'h8
`define OFS_FUNC_HIGH_DN 4'h9
`define OFS_FUNC_LOW_UP 4'hA
`define OFS_FUNC_LOW_DN 4'hB
`define OFS_XFER_STATUS 4'hC

// Reset values
`define RST_GROUP_MODE 8'hF0
`define RST_TRIGGER_SEL 8'hFF
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000

// Field layout
`define GROUP_MODE_RSVD 8'hF0
`define PIN_FUNC_PATTERN 2'h3
`define UNMAPPED_READ 8'h00

`endif

/* pattern_output_pkg.sv */
// Purpose: Types shared by the pattern output unit.
// Assumes: Constants live in pattern_output_map.svh.
// Notes: Register selector used by the address decoder.
package pattern_output_pkg;

   // Register selected by an address
   typedef enum {
      SEL_NEXT_LOW,
      SEL_NEXT_HIGH,
      SEL_ENABLE_LOW,
      SEL_ENABLE_HIGH,
      SEL_TRIGGER,
      SEL_GROUP_MODE,
      SEL_PORT_LOW,
      SEL_PORT_HIGH,
      SEL_FUNC_HIGH_UP,
      SEL_FUNC_HIGH_DN,
      SEL_FUNC_LOW_UP,
      SEL_FUNC_LOW_DN,
      SEL_XFER_STATUS,
      SEL_NONE
   } reg_sel_t;

   typedef logic [3:0] nibble_t;
   typedef logic [7:0] byte_t;
   typedef logic [15:0] word_t;

endpackage

/* group_xfer_if.sv */
// Purpose: Carries one group's settings and match strobes to its transfer unit.
// Assumes: One instance per group of four pins.
// Notes: load_mask and load_value come back combinationally.
`timescale 1ns/100ps
`default_nettype none
interface group_xfer_if;
   import pattern_output_pkg::*;
   nibble_t next_bits;
   nibble_t enable_bits;
   logic [1:0] chan_sel;
   logic nonoverlap;
   nibble_t match_a;
   nibble_t match_b;
   nibble_t load_mask;
   nibble_t load_value;

   modport top (output next_bits, enable_bits, chan_sel, nonoverlap, match_a, match_b,
                input load_mask, load_value);
   modport unit (input next_bits, enable_bits, chan_sel, nonoverlap, match_a, match_b,
                 output load_mask, load_value);
endinterface
`default_nettype wire

/* group_transfer_unit.sv */
// Purpose: Works out which bits of one group load from next-pattern data.
// Assumes: Match strobes are one-cycle pulses in the system clock domain.
// Notes: Purely combinational; the top registers the result.
`timescale 1ns/100ps
`default_nettype none
module group_transfer_unit (
   group_xfer_if.unit gx
);
   import pattern_output_pkg::*;

   logic hit_a;
   logic hit_b;

   // Pick the strobes of the channel this group listens to
   assign hit_a = gx.match_a[gx.chan_sel];
   assign hit_b = gx.match_b[gx.chan_sel];

   // Bits to load: match A moves all enabled bits, match B only zeros
   always_comb begin
      gx.load_mask = 4'h0;
      if (hit_a) begin
         gx.load_mask = gx.enable_bits;
      end else if (hit_b && gx.nonoverlap) begin
         gx.load_mask = gx.enable_bits & ~gx.next_bits;
      end
   end

   assign gx.load_value = gx.next_bits;
endmodule
`default_nettype wire

/* pattern_output_unit.sv */
// Purpose: Timed pattern output unit for sixteen port pins in four groups.
// Assumes: Timer match strobes are synchronous one-cycle pulses.
// Notes: Port data and pin enables come straight from flip-flops.
// Notes: Every software register is one byte wide, paired into words where needed.
`include "pattern_output_map.svh"
`timescale 1ns/100ps
`default_nettype none
module pattern_output_unit (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire pattern_output_pkg::byte_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output var pattern_output_pkg::byte_t reg_rdata,
   // Timer match strobes, one bit per channel
   input wire pattern_output_pkg::nibble_t match_a,
   input wire pattern_output_pkg::nibble_t match_b,
   // Pattern pins
   output var pattern_output_pkg::word_t pin_out,
   output var pattern_output_pkg::word_t pin_oe
);
   import pattern_output_pkg::*;

   // Address decoder shared by the write and read paths
   function automatic reg_sel_t decode(input logic [3:0] addr);
      reg_sel_t sel;
      sel = SEL_NONE;
      unique case (addr)
         `OFS_NEXT_LOW: sel = SEL_NEXT_LOW;
         `OFS_NEXT_HIGH: sel = SEL_NEXT_HIGH;
         `OFS_ENABLE_LOW: sel = SEL_ENABLE_LOW;
         `OFS_ENABLE_HIGH: sel = SEL_ENABLE_HIGH;
         `OFS_TRIGGER_SEL: sel = SEL_TRIGGER;
         `OFS_GROUP_MODE: sel = SEL_GROUP_MODE;
         `OFS_PORT_LOW: sel = SEL_PORT_LOW;
         `OFS_PORT_HIGH: sel = SEL_PORT_HIGH;
         `OFS_FUNC_HIGH_UP: sel = SEL_FUNC_HIGH_UP;
         `OFS_FUNC_HIGH_DN: sel = SEL_FUNC_HIGH_DN;
         `OFS_FUNC_LOW_UP: sel = SEL_FUNC_LOW_UP;
         `OFS_FUNC_LOW_DN: sel = SEL_FUNC_LOW_DN;
         `OFS_XFER_STATUS: sel = SEL_XFER_STATUS;
         default: sel = SEL_NONE;
      endcase
      return sel;
   endfunction

   // Decoded strobes
   reg_sel_t wr_sel;
   reg_sel_t rd_sel;
   // Software-visible registers, one byte each
   byte_t next_low_q;
   byte_t next_high_q;
   byte_t enable_low_q;
   byte_t enable_high_q;
   byte_t trigger_q;
   byte_t group_mode_q;
   byte_t func_high_up_q;
   byte_t func_high_dn_q;
   byte_t func_low_up_q;
   byte_t func_low_dn_q;
   // Sixteen-bit views of the byte pairs
   word_t next_q;
   word_t enable_q;
   word_t func_high_q;
   word_t func_low_q;
   // Transfer path
   word_t port_q;
   word_t port_d;
   word_t load_mask;
   word_t load_value;
   nibble_t group_hit_q;
   nibble_t group_hit_d;
   // Pin and read paths
   word_t pin_oe_d;
   byte_t rdata_d;

   // Write select, none without a write strobe
   assign wr_sel = reg_wr ? decode(reg_addr) : SEL_NONE;

   // Read select, none without a read strobe
   assign rd_sel = reg_rd ? decode(reg_addr) : SEL_NONE;

   // Next-pattern data for pins 7-0
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         next_low_q <= `RST_BYTE;
      end else if (wr_sel == SEL_NEXT_LOW) begin
         next_low_q <= reg_wdata;
      end
   end

   // Next-pattern data for pins 15-8
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         next_high_q <= `RST_BYTE;
      end else if (wr_sel == SEL_NEXT_HIGH) begin
         next_high_q <= reg_wdata;
      end
   end

   // Sixteen-bit view used by the transfer units
   assign next_q = {next_high_q, next_low_q};

   // Per-bit transfer enables for pins 7-0
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         enable_low_q <= `RST_BYTE;
      end else if (wr_sel == SEL_ENABLE_LOW) begin
         enable_low_q <= reg_wdata;
      end
   end

   // Per-bit transfer enables for pins 15-8
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         enable_high_q <= `RST_BYTE;
      end else if (wr_sel == SEL_ENABLE_HIGH) begin
         enable_high_q <= reg_wdata;
      end
   end

   // Sixteen-bit view of the enables
   assign enable_q = {enable_high_q, enable_low_q};

   // Trigger channel select, two bits per group
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         trigger_q <= `RST_TRIGGER_SEL;
      end else if (wr_sel == SEL_TRIGGER) begin
         trigger_q <= reg_wdata;
      end
   end

   // Group mode register; upper four bits forced to one on write
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         group_mode_q <= `RST_GROUP_MODE;
      end else if (wr_sel == SEL_GROUP_MODE) begin
         group_mode_q <= reg_wdata | `GROUP_MODE_RSVD;
      end
   end

   // Pin function fields for pins 15-12, two bits per pin
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         func_high_up_q <= `RST_BYTE;
      end else if (wr_sel == SEL_FUNC_HIGH_UP) begin
         func_high_up_q <= reg_wdata;
      end
   end

   // Pin function fields for pins 11-8
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         func_high_dn_q <= `RST_BYTE;
      end else if (wr_sel == SEL_FUNC_HIGH_DN) begin
         func_high_dn_q <= reg_wdata;
      end
   end

   // Pin function fields for pins 7-4
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         func_low_up_q <= `RST_BYTE;
      end else if (wr_sel == SEL_FUNC_LOW_UP) begin
         func_low_up_q <= reg_wdata;
      end
   end

   // Pin function fields for pins 3-0
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         func_low_dn_q <= `RST_BYTE;
      end else if (wr_sel == SEL_FUNC_LOW_DN) begin
         func_low_dn_q <= reg_wdata;
      end
   end

   // Per-bank views, lowest pin of each bank in bits 1:0
   assign func_high_q = {func_high_up_q, func_high_dn_q};
   assign func_low_q = {func_low_up_q, func_low_dn_q};

   // One transfer unit per group of four pins
   generate
      for (genvar g = 0; g < 4; g++) begin : gen_grp
         group_xfer_if gx();
         // Group settings towards the transfer unit
         assign gx.next_bits = next_q[4*g +: 4];
         assign gx.enable_bits = enable_q[4*g +: 4];
         assign gx.chan_sel = trigger_q[2*g +: 2];
         assign gx.nonoverlap = group_mode_q[g];
         assign gx.match_a = match_a;
         assign gx.match_b = match_b;
         // Bits this group loads on the current edge
         assign load_mask[4*g +: 4] = gx.load_mask;
         assign load_value[4*g +: 4] = gx.load_value;
         assign group_hit_d[g] = |gx.load_mask;
         // Strobe choice and masking for this group
         group_transfer_unit u_unit (
            .gx(gx.unit)
         );
      end
   endgenerate

   // Port data: a match transfer beats a software write on the same bit
   always_comb begin
      port_d = port_q;
      if (wr_sel == SEL_PORT_LOW) begin
         port_d[7:0] = reg_wdata;
      end
      if (wr_sel == SEL_PORT_HIGH) begin
         port_d[15:8] = reg_wdata;
      end
      // Transferred bits override the software write
      port_d = (port_d & ~load_mask) | (load_value & load_mask);
   end

   // Port data register, updated on the edge that samples the strobe
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         port_q <= `RST_WORD;
      end else begin
         port_q <= port_d;
      end
   end

   // Groups moved by the latest transfer, held until the next one
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         group_hit_q <= 4'h0;
      end else if (|group_hit_d) begin
         group_hit_q <= group_hit_d;
      end
   end

   // Two-bit function field of one pin within a bank of eight pins
   function automatic logic [1:0] pin_func(input word_t bank, input int unsigned slot);
      logic [1:0] field;
      field = bank[2*slot +: 2];
      return field;
   endfunction

   // Pin drives when its function field is pattern and its enable is set
   generate
      for (genvar p = 0; p < 8; p++) begin : gen_pin_low
         assign pin_oe_d[p] = (pin_func(func_low_q, p) == `PIN_FUNC_PATTERN) & enable_q[p];
      end
      for (genvar p = 8; p < 16; p++) begin : gen_pin_high
         assign pin_oe_d[p] = (pin_func(func_high_q, p - 8) == `PIN_FUNC_PATTERN)
                              & enable_q[p];
      end
   endgenerate

   // Pin registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pin_oe <= `RST_WORD;
      end else begin
         pin_oe <= pin_oe_d;
      end
   end

   // Pin levels, a copy of the port data register kept at the pins
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pin_out <= `RST_WORD;
      end else begin
         pin_out <= port_d;
      end
   end

   // Read data mux
   always_comb begin
      rdata_d = `UNMAPPED_READ;
      unique case (rd_sel)
         SEL_NEXT_LOW: rdata_d = next_q[7:0];
         SEL_NEXT_HIGH: rdata_d = next_q[15:8];
         SEL_ENABLE_LOW: rdata_d = enable_q[7:0];
         SEL_ENABLE_HIGH: rdata_d = enable_q[15:8];
         SEL_TRIGGER: rdata_d = trigger_q;
         SEL_GROUP_MODE: rdata_d = group_mode_q | `GROUP_MODE_RSVD;
         SEL_PORT_LOW: rdata_d = port_q[7:0];
         SEL_PORT_HIGH: rdata_d = port_q[15:8];
         SEL_FUNC_HIGH_UP: rdata_d = func_high_q[15:8];
         SEL_FUNC_HIGH_DN: rdata_d = func_high_q[7:0];
         SEL_FUNC_LOW_UP: rdata_d = func_low_q[15:8];
         SEL_FUNC_LOW_DN: rdata_d = func_low_q[7:0];
         SEL_XFER_STATUS: rdata_d = {4'h0, group_hit_q};
         SEL_NONE: rdata_d = `UNMAPPED_READ;
      endcase
   end

   // Read data stands for one cycle after the read strobe, else zero
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         reg_rdata <= `RST_BYTE;
      end else begin
         reg_rdata <= rdata_d;
      end
   end
endmodule
`default_nettype wire

/* pattern_output_unit_properties.sv */
// Purpose: Port-level assertions for the pattern output unit.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to the top module below.
`include "pattern_output_map.svh"
`timescale 1ns/100ps
`default_nettype none
module pattern_output_unit_properties (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire pattern_output_pkg::byte_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire pattern_output_pkg::byte_t reg_rdata,
   // Timer strobes
   input wire pattern_output_pkg::nibble_t match_a,
   input wire pattern_output_pkg::nibble_t match_b,
   // Pins
   input wire pattern_output_pkg::word_t pin_out,
   input wire pattern_output_pkg::word_t pin_oe
);
   import pattern_output_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Read port and pin behaviour
   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside read slot");
   a_mode_rsvd_ones: assert property ($past(reg_rd) && $past(reg_addr) == `OFS_GROUP_MODE
      |-> reg_rdata[7:4] == 4'hF) else $error("mode reserved bits not one");
   a_unmapped_read: assert property ($past(reg_rd) && $past(reg_addr) > `OFS_XFER_STATUS
      |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_pins_hold_quiet: assert property (!$past(sys_rst) && $past(match_a) == 4'h0
      && $past(match_b) == 4'h0 && !($past(reg_wr) && $past(reg_addr[3:1]) == 3'h3)
      |-> $stable(pin_out)) else $error("pins moved without a cause");
   a_b_never_sets: assert property ($past(match_a) == 4'h0 && $past(match_b) != 4'h0
      && !$past(reg_wr) |-> (pin_out & ~$past(pin_out)) == 16'h0000)
      else $error("match B raised a pin");
   a_oe_config_only: assert property (!$past(reg_wr) && !$past(reg_wr, 2)
      && !$past(sys_rst) && !$past(sys_rst, 2) |-> $stable(pin_oe))
      else $error("pin enable moved without a write");
   a_reset_quiet: assert property ($past(sys_rst) |-> pin_out == 16'h0000
      && pin_oe == 16'h0000 && reg_rdata == 8'h00) else $error("outputs not clear after reset");
   a_port_write_lands: assert property ($past(reg_wr) && $past(reg_addr) == `OFS_PORT_LOW
      && $past(match_a) == 4'h0 && $past(match_b) == 4'h0
      |-> pin_out[7:0] == $past(reg_wdata)) else $error("port write not on pins");
endmodule
bind pattern_output_unit pattern_output_unit_properties i_pattern_output_unit_properties (
   .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .match_a(match_a),
   .match_b(match_b), .pin_out(pin_out), .pin_oe(pin_oe)
);
`default_nettype wire

/* timer_match_model.sv */
// Purpose: Timer channel giving compare-match strobes.
// Assumes: Period sits in match B, gap in match A.
// Notes: Counter clears on match B.
`timescale 1ns/100ps
`default_nettype none
module timer_match_model (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Run control
   input wire logic run,
   input wire logic [1:0] chan,
   input wire logic [7:0] gap,
   input wire logic [7:0] period,
   // Strobes
   output var logic [3:0] match_a,
   output var logic [3:0] match_b
);
   logic [7:0] cnt_q;
   // Count cleared at the period
   always_ff @(posedge clock) begin
      if (sys_rst || !run) cnt_q <= 8'h00;
      else cnt_q <= (cnt_q == period - 8'h01) ? 8'h00 : cnt_q + 8'h01;
   end
   // One-cycle strobes on the chosen channel only
   always_ff @(posedge clock) begin
      match_a <= (!sys_rst && run && cnt_q == gap) ? 4'h1 << chan : 4'h0;
      match_b <= (!sys_rst && run && cnt_q == period - 8'h01) ? 4'h1 << chan : 4'h0;
   end
endmodule
`default_nettype wire

/* pattern_output_unit_tb.sv */
// Purpose: Self-checking bench for the pattern output unit.
// Assumes: Timer model drives the match strobes.
// Notes: Expected pins and reads queue up, a watcher compares.
`include "pattern_output_map.svh"
`timescale 1ns/100ps
`default_nettype none
module pattern_output_unit_tb;
   import pattern_output_pkg::*;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   byte_t reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   byte_t reg_rdata;
   nibble_t match_a;
   nibble_t match_b;
   word_t pin_out;
   word_t pin_oe;
   logic run = 1'b0;
   logic refill = 1'b0;
   logic [1:0] chan = 2'h0;
   byte_t gap = 8'h00;
   word_t nx = 16'h0000, en = 16'h0000, pt = 16'h0000, r;
   byte_t tr = 8'hFF;
   nibble_t md = 4'h0, hs = 4'h0, hn;
   word_t pq[$], rq[$];
   logic rd_p = 1'b0, mt_p = 1'b0;
   int failures = 0, n_checks = 0, ch;
   pattern_output_unit i_pattern_output_unit (
      .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .match_a(match_a),
      .match_b(match_b), .pin_out(pin_out), .pin_oe(pin_oe)
   );
   timer_match_model i_timer_match_model (
      .clock(clock), .sys_rst(sys_rst), .run(run), .chan(chan), .gap(gap),
      .period(8'h0C), .match_a(match_a), .match_b(match_b)
   );
   // Bus cycles, one idle edge after each strobe
   task automatic wr(input logic [3:0] a, input byte_t d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [3:0] a, input byte_t e);
      rq.push_back({8'h00, e});
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(posedge clock);
   endtask
   task automatic chk(input string nm, input word_t e, input word_t g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wrap_up;
      if (pq.size() + rq.size() != 0) begin
         failures++;
         $display("mismatch pending_notes expected 0 seen %0d", pq.size() + rq.size());
      end
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Clock
   initial begin
      forever #2 clock = ~clock;
   end
   // Shadow registers and expected pins on every strobe
   always @(posedge clock) begin
      if (!sys_rst && (match_a != 4'h0 || match_b != 4'h0)) begin
         hn = 4'h0;
         for (int i = 0; i < 16; i++) begin
            ch = tr[2 * (i / 4) +: 2];
            if (en[i] && (match_a[ch] || (match_b[ch] && md[i / 4] && !nx[i]))) begin
               pt[i] = nx[i];
               hn[i / 4] = 1'b1;
            end
         end
         if (hn != 4'h0) hs = hn;
         pq.push_back(pt);
      end
      if (reg_wr) begin
         case (reg_addr)
            `OFS_NEXT_LOW: nx[7:0] = reg_wdata;
            `OFS_NEXT_HIGH: nx[15:8] = reg_wdata;
            `OFS_ENABLE_LOW: en[7:0] = reg_wdata;
            `OFS_ENABLE_HIGH: en[15:8] = reg_wdata;
            `OFS_TRIGGER_SEL: tr = reg_wdata;
            `OFS_GROUP_MODE: md = reg_wdata[3:0];
            `OFS_PORT_LOW: pt[7:0] = reg_wdata;
            `OFS_PORT_HIGH: pt[15:8] = reg_wdata;
            default: ;
         endcase
      end
   end
   // Watcher takes the oldest note when a result appears
   always @(posedge clock) begin
      if (rd_p) chk("reg_rdata", rq.pop_front(), {8'h00, reg_rdata});
      if (mt_p) chk("pin_out", pq.pop_front(), pin_out);
      rd_p = reg_rd && !sys_rst;
      mt_p = !sys_rst && (match_a != 4'h0 || match_b != 4'h0);
   end
   // Fresh next data after each match A, as an interrupt routine would
   always @(posedge clock) begin
      if (refill && match_a != 4'h0) begin
         wr(`OFS_NEXT_LOW, 8'($urandom));
         wr(`OFS_NEXT_HIGH, 8'($urandom));
      end
   end
   // Main sequence
   initial begin
      void'($urandom(38));
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      rd(`OFS_GROUP_MODE, `RST_GROUP_MODE);
      rd(`OFS_TRIGGER_SEL, `RST_TRIGGER_SEL);
      rd(4'hD, `UNMAPPED_READ);
      wr(`OFS_GROUP_MODE, 8'h00);
      rd(`OFS_GROUP_MODE, `GROUP_MODE_RSVD);
      for (int i = 8; i < 12; i++) begin
         wr(4'(i), 8'hFF);
      end
      r = 16'($urandom);
      wr(`OFS_ENABLE_LOW, r[7:0]);
      wr(`OFS_ENABLE_HIGH, r[15:8]);
      r = 16'($urandom);
      wr(`OFS_PORT_LOW, r[7:0]);
      wr(`OFS_PORT_HIGH, r[15:8]);
      repeat (2) @(posedge clock);
      chk("pin_oe", en, pin_oe);
      chk("pin_out", pt, pin_out);
      wr(`OFS_FUNC_LOW_DN, 8'h3C);
      repeat (2) @(posedge clock);
      chk("pin_oe", en & 16'hFFF6, pin_oe);
      wr(`OFS_FUNC_LOW_DN, 8'hFF);
      for (int c = 0; c < 4; c++) begin
         r = 16'($urandom);
         wr(`OFS_TRIGGER_SEL, {r[7:2], 2'(c)});
         wr(`OFS_GROUP_MODE, {4'hF, r[11:8]});
         wr(`OFS_NEXT_LOW, r[15:8]);
         wr(`OFS_NEXT_HIGH, r[7:0]);
         chan <= 2'(c);
         gap <= 8'(c);
         run <= 1'b1;
         refill <= 1'b1;
         repeat (40) @(posedge clock);
         run <= 1'b0;
         refill <= 1'b0;
         repeat (8) @(posedge clock);
         rd(`OFS_XFER_STATUS, {4'h0, hs});
      end
      repeat (2) @(posedge clock);
      wrap_up();
   end
   // Watchdog
   initial begin
      repeat (3000) @(posedge clock);
      failures++;
      wrap_up();
   end
endmodule
`default_nettype wire
